// ---- logic/bvs_chan_if.sv ----
interface bvs_chan_if;
  logic wr_stb;
  logic [7:0] wdata;
  logic go;
  logic [7:0] reg_val;
  logic [5:0] code_applied;
  logic blank_active;
  modport chan (input wr_stb, input wdata, input go,
                output reg_val, output code_applied, output blank_active);
  modport ctrl (output wr_stb, output wdata, output go,
                input reg_val, input code_applied, input blank_active);
endinterface

// ---- logic/bvs_channel.sv ----
module bvs_channel #(
  parameter int BLANK_CYCLES = bvs_pkg::BLANK_CYCLES_DFLT
) (
  input wire logic i_clock,
  input wire logic i_reset,
  bvs_chan_if.chan ch
);
  import bvs_pkg::*;

  localparam int CW = $clog2(BLANK_CYCLES + 1);
  localparam logic [CW-1:0] CNT_LOAD = CW'(BLANK_CYCLES - 1);
  localparam logic [CW-1:0] CNT_ZERO = '0;
  localparam logic [CW-1:0] CNT_ONE = CW'(1);

  logic [7:0] reg_r;
  logic [5:0] applied_r;
  bvs_blank_t blank_r;
  logic [CW-1:0] cnt_r;

  // ----------------------------------------
  // Setting register
  // ----------------------------------------
  always_ff @(posedge i_clock or posedge i_reset) begin
    if (i_reset) begin
      reg_r <= REG_RESET;
    end else if (ch.wr_stb) begin
      reg_r <= ch.wdata & REG_WMASK;
    end
  end

  // Output voltage moves only on a go command, never on the write itself
  always_ff @(posedge i_clock or posedge i_reset) begin
    if (i_reset) begin
      applied_r <= CODE_RESET;
    end else if (ch.go) begin
      applied_r <= reg_r[CODE_MSB:0];
    end
  end

  // ----------------------------------------
  // Monitor blanking
  // ----------------------------------------
  // A write during blanking restarts the full interval
  always_ff @(posedge i_clock or posedge i_reset) begin
    if (i_reset) begin
      blank_r <= BVS_BLANK_IDLE;
      cnt_r <= CNT_ZERO;
    end else if (ch.wr_stb) begin
      blank_r <= BVS_BLANK_RUN;
      cnt_r <= CNT_LOAD;
    end else begin
      unique case (blank_r)
        BVS_BLANK_IDLE: begin
          cnt_r <= CNT_ZERO;
        end
        BVS_BLANK_RUN: begin
          if (cnt_r == CNT_ZERO) begin
            blank_r <= BVS_BLANK_IDLE;
          end else begin
            cnt_r <= cnt_r - CNT_ONE;
          end
        end
      endcase
    end
  end

  assign ch.reg_val = reg_r;
  assign ch.code_applied = applied_r;
  assign ch.blank_active = (blank_r == BVS_BLANK_RUN);

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  property p_rsvd_zero;
    @(posedge i_clock) disable iff (i_reset) reg_r[RSVD_BIT] == 1'b0;
  endproperty
  a_rsvd_zero: assert property (p_rsvd_zero) else $error("reserved bit set");

  property p_write_load;
    @(posedge i_clock) disable iff (i_reset)
      ch.wr_stb |=> reg_r == ($past(ch.wdata) & REG_WMASK);
  endproperty
  a_write_load: assert property (p_write_load) else $error("write not stored");

  sequence s_write;
    ch.wr_stb;
  endsequence
  sequence s_blank_hold;
    ch.blank_active [*8];
  endsequence
  property p_blank_start;
    @(posedge i_clock) disable iff (i_reset) s_write |=> s_blank_hold;
  endproperty
  a_blank_start: assert property (p_blank_start) else $error("blanking not held");

  property p_blank_end;
    @(posedge i_clock) disable iff (i_reset)
      (ch.blank_active && cnt_r == CNT_ZERO && !ch.wr_stb) |=> !ch.blank_active;
  endproperty
  a_blank_end: assert property (p_blank_end) else $error("blanking overran");

  property p_hold_no_go;
    @(posedge i_clock) disable iff (i_reset) !ch.go |=> $stable(applied_r);
  endproperty
  a_hold_no_go: assert property (p_hold_no_go) else $error("code moved without go");

  property p_apply_go;
    @(posedge i_clock) disable iff (i_reset)
      ch.go |=> applied_r == $past(reg_r[CODE_MSB:0]);
  endproperty
  a_apply_go: assert property (p_apply_go) else $error("go did not apply code");
endmodule

// ---- logic/bvs_pkg.sv ----
package bvs_pkg;
  // ----------------------------------------
  // Register map
  // ----------------------------------------
  localparam logic [7:0] OFF_BUCK1 = 8'h16;
  localparam logic [7:0] OFF_BUCK2 = 8'h17;
  localparam logic [7:0] REG_RESET = 8'h99;
  localparam logic [7:0] REG_WMASK = 8'hbf;
  localparam int PSKIP_BIT = 7;
  localparam int RSVD_BIT = 6;
  localparam int CODE_MSB = 5;
  localparam logic [5:0] CODE_RESET = 6'h19;
  localparam logic [7:0] READ_ZERO = 8'h00;
  // ----------------------------------------
  // Code to millivolt mapping
  // ----------------------------------------
  localparam logic [5:0] CODE_KNEE = 6'h32;
  localparam logic [10:0] MV_BASE = 11'h352;
  localparam logic [10:0] MV_KNEE = 11'h546;
  localparam logic [10:0] MV_TOP = 11'h68b;
  localparam logic [10:0] MV_FINE_STEP = 11'h00a;
  localparam logic [10:0] MV_COARSE_STEP = 11'h019;
  // ----------------------------------------
  // Monitor blanking time
  // ----------------------------------------
  localparam int BLANK_TIME_US = 5000;
  localparam int CLK_PERIOD_NS = 10;
  localparam int BLANK_CYCLES_DFLT = BLANK_TIME_US * 1000 / CLK_PERIOD_NS;
  typedef enum logic {
    BVS_BLANK_IDLE = 1'b0,
    BVS_BLANK_RUN = 1'b1
  } bvs_blank_t;
endpackage

// ---- logic/bvs_regs.sv ----
// Summary of operation
// - Buck1 code bits 5-0, reset 19h.
// - Code maps 0.85 V, 10 mV, then 25 mV.
// - Buck2 register at 0x17, resets 0x99.
// - Buck2 code six bits, reset 19h, same map.
// - Top bit enables pulse skip, reset one.
// - Writes accepted only when password satisfied.
// - Write blanks voltage monitors for 5 ms.
// - Buck2 code applies on go or alternate go.
// - Buck1 at 0x16, same reset, lock, blanking.
// - Buck1 code applies on go or alternate go.
module bvs_regs #(
  parameter int BLANK_CYCLES = bvs_pkg::BLANK_CYCLES_DFLT
) (
  input wire logic i_clock,
  input wire logic i_reset,
  input wire logic i_wr_en,
  input wire logic i_rd_en,
  input wire logic [7:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_unlocked,
  input wire logic i_apply_go,
  input wire logic i_voltage_apply_alt_trigger,
  output logic [7:0] o_rdata,
  output logic [5:0] o_buck1_voltage_code,
  output logic [5:0] o_buck2_voltage_code,
  output logic [10:0] o_buck1_mv,
  output logic [10:0] o_buck2_mv,
  output logic o_buck1_pulse_skip_enable,
  output logic o_buck2_pulse_skip_enable,
  output logic o_buck1_monitor_blank,
  output logic o_buck2_monitor_blank
);
  import bvs_pkg::*;

  bvs_chan_if ch1 ();
  bvs_chan_if ch2 ();

  logic go;
  logic [7:0] rdata_r;
  logic [10:0] mv1_r;
  logic [10:0] mv2_r;

  localparam logic [10:0] MV_RESET = MV_BASE + 11'(MV_FINE_STEP * 11'(CODE_RESET));
  localparam logic [5:0] CODE_ZERO = '0;
  localparam logic [5:0] CODE_TOP = '1;

  function automatic logic [10:0] code_mv(input logic [5:0] c);
    logic [10:0] steps;
    steps = 11'(c);
    if (c <= CODE_KNEE) begin
      code_mv = MV_BASE + 11'(MV_FINE_STEP * steps);
    end else begin
      code_mv = MV_KNEE + 11'(MV_COARSE_STEP * (steps - 11'(CODE_KNEE)));
    end
  endfunction

  // ----------------------------------------
  // Write decode
  // ----------------------------------------
  // Locked writes are dropped silently and do not start blanking
  assign go = i_apply_go | i_voltage_apply_alt_trigger;
  assign ch1.wr_stb = i_wr_en && i_unlocked && (i_addr == OFF_BUCK1);
  assign ch2.wr_stb = i_wr_en && i_unlocked && (i_addr == OFF_BUCK2);
  assign ch1.wdata = i_wdata;
  assign ch2.wdata = i_wdata;
  assign ch1.go = go;
  assign ch2.go = go;

  bvs_channel #(.BLANK_CYCLES(BLANK_CYCLES)) u_buck1 (
    .i_clock(i_clock),
    .i_reset(i_reset),
    .ch(ch1)
  );

  bvs_channel #(.BLANK_CYCLES(BLANK_CYCLES)) u_buck2 (
    .i_clock(i_clock),
    .i_reset(i_reset),
    .ch(ch2)
  );

  // ----------------------------------------
  // Read path
  // ----------------------------------------
  always_ff @(posedge i_clock or posedge i_reset) begin
    if (i_reset) begin
      rdata_r <= READ_ZERO;
    end else if (i_rd_en) begin
      if (i_addr == OFF_BUCK1) begin
        rdata_r <= ch1.reg_val;
      end else if (i_addr == OFF_BUCK2) begin
        rdata_r <= ch2.reg_val;
      end else begin
        rdata_r <= READ_ZERO;
      end
    end
  end

  // ----------------------------------------
  // Voltage outputs
  // ----------------------------------------
  // Registered for clean outputs, so millivolts trail the code by one cycle
  always_ff @(posedge i_clock or posedge i_reset) begin
    if (i_reset) begin
      mv1_r <= MV_RESET;
      mv2_r <= MV_RESET;
    end else begin
      mv1_r <= code_mv(ch1.code_applied);
      mv2_r <= code_mv(ch2.code_applied);
    end
  end

  assign o_rdata = rdata_r;
  assign o_buck1_voltage_code = ch1.code_applied;
  assign o_buck2_voltage_code = ch2.code_applied;
  assign o_buck1_mv = mv1_r;
  assign o_buck2_mv = mv2_r;
  assign o_buck1_pulse_skip_enable = ch1.reg_val[PSKIP_BIT];
  assign o_buck2_pulse_skip_enable = ch2.reg_val[PSKIP_BIT];
  assign o_buck1_monitor_blank = ch1.blank_active;
  assign o_buck2_monitor_blank = ch2.blank_active;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  property p_locked_ignore;
    @(posedge i_clock) disable iff (i_reset)
      (i_wr_en && !i_unlocked) |=> ($stable(ch1.reg_val) && $stable(ch2.reg_val));
  endproperty
  a_locked_ignore: assert property (p_locked_ignore) else $error("locked write took");

  property p_mv_range;
    @(posedge i_clock) disable iff (i_reset) o_buck1_mv >= MV_BASE && o_buck1_mv <= MV_TOP;
  endproperty
  a_mv_range: assert property (p_mv_range) else $error("millivolts out of range");

  property p_mv_knee;
    @(posedge i_clock) disable iff (i_reset)
      (ch2.code_applied == CODE_KNEE) |=> o_buck2_mv == MV_KNEE;
  endproperty
  a_mv_knee: assert property (p_mv_knee) else $error("knee voltage wrong");

  property p_read_buck2;
    @(posedge i_clock) disable iff (i_reset)
      (i_rd_en && i_addr == OFF_BUCK2) |=> o_rdata == $past(ch2.reg_val);
  endproperty
  a_read_buck2: assert property (p_read_buck2) else $error("bad read data");

  property p_reset_code;
    @(posedge i_clock) $fell(i_reset) |-> (o_buck1_voltage_code == CODE_RESET
      && ch2.reg_val == REG_RESET);
  endproperty
  a_reset_code: assert property (p_reset_code) else $error("bad reset value");

  property p_mv_range2;
    @(posedge i_clock) disable iff (i_reset) o_buck2_mv >= MV_BASE && o_buck2_mv <= MV_TOP;
  endproperty
  a_mv_range2: assert property (p_mv_range2) else $error("buck2 millivolts out of range");

  property p_mv_base;
    @(posedge i_clock) disable iff (i_reset)
      (o_buck1_voltage_code == CODE_ZERO) |=> o_buck1_mv == MV_BASE;
  endproperty
  a_mv_base: assert property (p_mv_base) else $error("lowest code voltage wrong");

  property p_mv_top;
    @(posedge i_clock) disable iff (i_reset)
      (o_buck1_voltage_code == CODE_TOP) |=> o_buck1_mv == MV_TOP;
  endproperty
  a_mv_top: assert property (p_mv_top) else $error("highest code voltage wrong");

  // Go settles the code first and the millivolts one cycle later
  sequence s_go_knee;
    go && ch2.reg_val[CODE_MSB:0] == CODE_KNEE;
  endsequence
  sequence s_knee_settle;
    (o_buck2_voltage_code == CODE_KNEE) ##1 (o_buck2_mv == MV_KNEE);
  endsequence
  property p_go_knee;
    @(posedge i_clock) disable iff (i_reset) s_go_knee |=> s_knee_settle;
  endproperty
  a_go_knee: assert property (p_go_knee) else $error("go to knee did not settle");

  property p_read_buck1;
    @(posedge i_clock) disable iff (i_reset)
      (i_rd_en && i_addr == OFF_BUCK1) |=> o_rdata == $past(ch1.reg_val);
  endproperty
  a_read_buck1: assert property (p_read_buck1) else $error("bad buck1 read data");

  property p_read_unmapped;
    @(posedge i_clock) disable iff (i_reset)
      (i_rd_en && i_addr != OFF_BUCK1 && i_addr != OFF_BUCK2) |=> o_rdata == READ_ZERO;
  endproperty
  a_read_unmapped: assert property (p_read_unmapped) else $error("unmapped read not zero");

  // Read data stands between reads so a slow host can still pick it up
  property p_rdata_hold;
    @(posedge i_clock) disable iff (i_reset) !i_rd_en |=> $stable(o_rdata);
  endproperty
  a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved");

  property p_rsvd_read;
    @(posedge i_clock) disable iff (i_reset) i_rd_en |=> o_rdata[RSVD_BIT] == 1'b0;
  endproperty
  a_rsvd_read: assert property (p_rsvd_read) else $error("reserved bit read as one");

  property p_pskip_write1;
    @(posedge i_clock) disable iff (i_reset)
      ch1.wr_stb |=> o_buck1_pulse_skip_enable == $past(i_wdata[PSKIP_BIT]);
  endproperty
  a_pskip_write1: assert property (p_pskip_write1) else $error("buck1 skip bit lost");

  property p_pskip_write2;
    @(posedge i_clock) disable iff (i_reset)
      ch2.wr_stb |=> o_buck2_pulse_skip_enable == $past(i_wdata[PSKIP_BIT]);
  endproperty
  a_pskip_write2: assert property (p_pskip_write2) else $error("buck2 skip bit lost");

  property p_blank_locked;
    @(posedge i_clock) disable iff (i_reset)
      (i_wr_en && !i_unlocked && !o_buck2_monitor_blank) |=> !o_buck2_monitor_blank;
  endproperty
  a_blank_locked: assert property (p_blank_locked) else $error("locked write blanked");

  property p_blank_write1;
    @(posedge i_clock) disable iff (i_reset) ch1.wr_stb |=> o_buck1_monitor_blank;
  endproperty
  a_blank_write1: assert property (p_blank_write1) else $error("buck1 write not blanked");

  property p_reset_rest;
    @(posedge i_clock) $fell(i_reset) |-> (o_buck2_voltage_code == CODE_RESET
      && ch1.reg_val == REG_RESET && o_buck1_mv == MV_RESET && o_rdata == READ_ZERO
      && !o_buck1_monitor_blank && !o_buck2_monitor_blank);
  endproperty
  a_reset_rest: assert property (p_reset_rest) else $error("bad reset state");
endmodule

// ---- verif/buck_voltage_setting_regs_tb.sv ----
module buck_voltage_setting_regs_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import bvs_pkg::*;
  // ----------------------------------------
  // Bench signals
  // ----------------------------------------
  // Short blanking keeps the run brief; the lapse wait and the blanking length check derive from it
  localparam int BLANK = 20;
  typedef struct packed {
    logic [7:0] a;
    logic [7:0] d;
    logic unl;
    logic [7:0] exp;
  } bvs_row_t;
  logic i_clock = 1'b0;
  logic i_reset = 1'b1;
  logic wr_en, rd_en, unl, go1, go2, ps1, ps2, bl1, bl2;
  logic [7:0] addr, wdata, rdata, rv;
  logic [5:0] code1, code2;
  logic [10:0] mv1, mv2;
  int fail_count = 0;
  int compares = 0;
  int n;
  bvs_row_t rows [6] = '{'{8'h16, 8'hff, 1'b1, 8'hbf}, '{8'h17, 8'h40, 1'b1, 8'h00},
    '{8'h16, 8'h3f, 1'b0, 8'hbf}, '{8'h18, 8'haa, 1'b1, 8'h00},
    '{8'h17, 8'hb2, 1'b1, 8'hb2}, '{8'h16, 8'h7f, 1'b1, 8'h3f}};
  always #5 i_clock = ~i_clock;
  bvs_host_model u_bvs_host_model (.i_clock(i_clock), .i_rdata(rdata), .o_wr_en(wr_en),
    .o_rd_en(rd_en), .o_addr(addr), .o_wdata(wdata), .o_unlocked(unl),
    .o_apply_go(go1), .o_alt_go(go2));
  bvs_regs #(.BLANK_CYCLES(BLANK)) u_bvs_regs (.i_clock(i_clock), .i_reset(i_reset),
    .i_wr_en(wr_en), .i_rd_en(rd_en), .i_addr(addr), .i_wdata(wdata), .i_unlocked(unl),
    .i_apply_go(go1), .i_voltage_apply_alt_trigger(go2), .o_rdata(rdata),
    .o_buck1_voltage_code(code1), .o_buck2_voltage_code(code2), .o_buck1_mv(mv1),
    .o_buck2_mv(mv2), .o_buck1_pulse_skip_enable(ps1), .o_buck2_pulse_skip_enable(ps2),
    .o_buck1_monitor_blank(bl1), .o_buck2_monitor_blank(bl2));
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [10:0] mv(input logic [5:0] c);
    if (c <= 6'h32) begin
      return 11'h352 + 11'h00a * c;
    end
    return 11'h546 + 11'h019 * (c - 6'h32);
  endfunction
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic tally_and_finish;
    $display("compares=%0d fail_count=%0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // ----------------------------------------
  // Sequence
  // ----------------------------------------
  initial begin
    repeat (4) @(posedge i_clock);
    i_reset <= 1'b0;
    #1;
    check(16'({code1, code2}), 16'({6'h19, 6'h19}));
    check(16'(mv1), 16'(mv(6'h19)));
    check(16'(mv2), 16'(mv(6'h19)));
    check(16'({ps1, ps2, bl1, bl2, rdata}), 16'({4'hc, 8'h00}));
    u_bvs_host_model.rd(8'h16, rv);
    check(16'(rv), 16'h0099);
    u_bvs_host_model.rd(8'h17, rv);
    check(16'(rv), 16'h0099);
    foreach (rows[i]) begin
      u_bvs_host_model.wr(rows[i].a, rows[i].d, rows[i].unl);
      u_bvs_host_model.rd(rows[i].a, rv);
      check(16'(rv), 16'(rows[i].exp));
      if (rows[i].a != 8'h18) begin
        check(16'(rows[i].a[0] ? ps2 : ps1), 16'(rows[i].exp[7]));
      end
    end
    check(16'({code1, code2}), 16'({6'h19, 6'h19}));
    u_bvs_host_model.go(1'b0);
    #1;
    check(16'({code1, code2}), 16'({6'h3f, 6'h32}));
    @(posedge i_clock);
    #1;
    check(16'(mv1), 16'(mv(6'h3f)));
    check(16'(mv2), 16'(mv(6'h32)));
    u_bvs_host_model.wr(8'h16, 8'h80, 1'b1);
    u_bvs_host_model.wr(8'h17, 8'h05, 1'b1);
    u_bvs_host_model.go(1'b1);
    #1;
    check(16'({code1, code2}), 16'({6'h00, 6'h05}));
    @(posedge i_clock);
    #1;
    check(16'(mv1), 16'(mv(6'h00)));
    check(16'(mv2), 16'(mv(6'h05)));
    // Let earlier blanking lapse so a refused write cannot hide behind it
    repeat (BLANK + 10) @(posedge i_clock);
    u_bvs_host_model.wr(8'h17, 8'h00, 1'b0);
    #1;
    check(16'({bl1, bl2}), 16'h0000);
    u_bvs_host_model.rd(8'h17, rv);
    check(16'(rv), 16'h0005);
    u_bvs_host_model.wr(8'h16, 8'h99, 1'b1);
    #1;
    n = 0;
    while (bl1 === 1'b1 && n < 100) begin
      @(posedge i_clock);
      #1;
      n++;
    end
    check(n[15:0], BLANK[15:0]);
    check(16'(bl2), 16'h0000);
    // Reset in mid-blanking must drop the setting, the code and the blanking
    u_bvs_host_model.wr(8'h17, 8'h2a, 1'b1);
    u_bvs_host_model.go(1'b0);
    #1;
    check(16'({bl2, code2}), 16'({1'b1, 6'h2a}));
    @(posedge i_clock);
    i_reset <= 1'b1;
    repeat (2) @(posedge i_clock);
    i_reset <= 1'b0;
    #1;
    check(16'({code1, code2}), 16'({6'h19, 6'h19}));
    check(16'({ps2, bl1, bl2, rdata}), 16'({3'b100, 8'h00}));
    u_bvs_host_model.rd(8'h17, rv);
    check(16'(rv), 16'h0099);
    tally_and_finish();
  end
endmodule

// ---- verif/bvs_host_model.sv ----
module bvs_host_model (
  input wire logic i_clock,
  input wire logic [7:0] i_rdata,
  output logic o_wr_en,
  output logic o_rd_en,
  output logic [7:0] o_addr,
  output logic [7:0] o_wdata,
  output logic o_unlocked,
  output logic o_apply_go,
  output logic o_alt_go
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    o_wr_en = 1'b0;
    o_rd_en = 1'b0;
    o_addr = 8'h00;
    o_wdata = 8'h00;
    o_unlocked = 1'b0;
    o_apply_go = 1'b0;
    o_alt_go = 1'b0;
  end
  // ----------------------------------------
  // Bus cycles
  // ----------------------------------------
  // Unlock opens only around its own write; released lines show inverted data
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic unl);
    @(posedge i_clock);
    o_wr_en <= 1'b1;
    o_addr <= a;
    o_wdata <= d;
    o_unlocked <= unl;
    @(posedge i_clock);
    o_wr_en <= 1'b0;
    o_unlocked <= 1'b0;
    o_addr <= ~a;
    o_wdata <= ~d;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge i_clock);
    o_rd_en <= 1'b1;
    o_addr <= a;
    @(posedge i_clock);
    o_rd_en <= 1'b0;
    o_addr <= ~a;
    #1 d = i_rdata;
  endtask
  // Either go pulse makes the stored codes take effect
  task automatic go(input logic alt);
    @(posedge i_clock);
    o_apply_go <= !alt;
    o_alt_go <= alt;
    @(posedge i_clock);
    o_apply_go <= 1'b0;
    o_alt_go <= 1'b0;
  endtask
endmodule
